/* rtl/rtdc_pkg.sv */
package rtdc_pkg;

    // ---------------------------------------------------------------
    // holding register addresses
    // ---------------------------------------------------------------
    localparam logic [15:0] RTDC_MEAS_ADDR  = 16'h9c45;
    localparam logic [15:0] RTDC_CFG_ADDR   = 16'h9c67;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RTDC_CFG_RESET  = 16'h0002;
    localparam logic [15:0] RTDC_MEAS_RESET = 16'h0000;

    // ---------------------------------------------------------------
    // configuration field layout
    // ---------------------------------------------------------------
    localparam int          RTDC_TYPE_MSB   = 7;
    localparam int          RTDC_TYPE_LSB   = 6;
    localparam int          RTDC_QTY_BIT    = 5;
    localparam int          RTDC_WIRE_BIT   = 4;
    localparam int          RTDC_REJ_BIT    = 3;
    localparam int          RTDC_FILT_MSB   = 2;
    localparam int          RTDC_FILT_LSB   = 0;
    localparam int          RTDC_USED_MSB   = 7;
    localparam logic [7:0]  RTDC_UPPER_ZERO = 8'h00;

    // ---------------------------------------------------------------
    // scaling
    // ---------------------------------------------------------------
    localparam int          RTDC_RES_W      = 20;
    localparam logic [19:0] RTDC_RES_DIV    = 20'h0_000a;
    localparam logic [19:0] RTDC_WORD_MAX   = 20'h0_ffff;

    typedef enum logic [1:0] {
        RTDC_PLAT_100  = 2'h0,
        RTDC_NICK_100  = 2'h1,
        RTDC_PLAT_500  = 2'h2,
        RTDC_PLAT_1000 = 2'h3
    } rtdc_sensor_t;

endpackage

/* rtl/rtdc_scale.sv */
`timescale 1ns/100ps

module rtdc_scale #(
    parameter int RES_W = rtdc_pkg::RTDC_RES_W
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 conv_valid,
    input  wire logic [15:0]          conv_temp,
    input  wire logic [RES_W-1:0]     conv_res,
    input  wire rtdc_pkg::rtdc_sensor_t sensor_type,
    input  wire logic                 report_resistance,
    output logic      [15:0]          meas,
    output logic                      meas_update
);

    // ---------------------------------------------------------------
    // scaling helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] sat_word(input logic [RES_W-1:0] v);
        logic [15:0] r;
        r = (v > RES_W'(rtdc_pkg::RTDC_WORD_MAX)) ? 16'hffff : v[15:0];
        return r;
    endfunction

    function automatic logic tenth_ohm(input rtdc_pkg::rtdc_sensor_t t);
        return (t == rtdc_pkg::RTDC_PLAT_500) || (t == rtdc_pkg::RTDC_PLAT_1000);
    endfunction

    logic [RES_W-1:0] res_tenth;

    assign res_tenth = conv_res / RES_W'(rtdc_pkg::RTDC_RES_DIV);

    // ---------------------------------------------------------------
    // measurement word, latched per conversion
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meas <= rtdc_pkg::RTDC_MEAS_RESET;
        end else if (conv_valid) begin
            if (!report_resistance) begin
                meas <= conv_temp; // R7
            end else if (tenth_ohm(sensor_type)) begin
                meas <= sat_word(res_tenth); // R9
            end else begin
                meas <= sat_word(conv_res); // R8
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meas_update <= 1'b0;
        end else begin
            meas_update <= conv_valid; // R10
        end
    end

endmodule // rtdc_scale

/* rtl/rtdc_channel.sv */
`timescale 1ns/100ps

// Functional notes
// R1: bits 7:6 of the configuration pick platinum 100, nickel 100, platinum 500 or platinum 1000, resetting to 0.
// R2: configuration bit 5 reports temperature when 0 and resistance when 1, resetting to 0.
// R3: configuration bit 4 selects two/four-wire when 0 and three-wire when 1, resetting to 0.
// R4: configuration bit 3 selects 50 Hz rejection when 0 and 60 Hz when 1, resetting to 0.
// R5: configuration bits 2:0 pick the input filter and reset to 3'b010.
// R6: configuration bits 15:8 do nothing and no value written there changes the channel.
// R7: with temperature reporting the measurement word holds tenths of a degree Celsius.
// R8: with resistance reporting on a 100 ohm sensor the word holds hundredths of an ohm.
// R9: with resistance reporting on a 500 or 1000 ohm sensor the word holds tenths of an ohm.
// R10: upper configuration bits read zero and a new setting applies from the next stored result.
module rtdc_channel #(
    parameter int RES_W = rtdc_pkg::RTDC_RES_W
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [15:0]            reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [15:0]            reg_wdata,
    output logic      [15:0]            reg_rdata,
    output logic                        reg_ack,
    output logic                        reg_err,
    input  wire logic                   conv_valid,
    input  wire logic [15:0]            conv_temp,
    input  wire logic [RES_W-1:0]       conv_res,
    output rtdc_pkg::rtdc_sensor_t      sensor_type,
    output logic                        report_resistance,
    output logic                        three_wire,
    output logic                        reject_60hz,
    output logic      [2:0]             filter_sel,
    output logic      [15:0]            third_analog_channel,
    output logic                        meas_update
);

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    function automatic logic hit_cfg(input logic [15:0] a);
        return a == rtdc_pkg::RTDC_CFG_ADDR;
    endfunction

    function automatic logic hit_meas(input logic [15:0] a);
        return a == rtdc_pkg::RTDC_MEAS_ADDR;
    endfunction

    logic [7:0]  cfg;
    logic        req;
    logic        wr_cfg;

    assign req    = reg_wr || reg_rd;
    assign wr_cfg = reg_wr && hit_cfg(reg_addr);

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg <= rtdc_pkg::RTDC_CFG_RESET[rtdc_pkg::RTDC_USED_MSB:0]; // R1 R2 R3 R4 R5
        end else if (wr_cfg) begin
            cfg <= reg_wdata[rtdc_pkg::RTDC_USED_MSB:0]; // R6
        end
    end

    assign sensor_type       = rtdc_pkg::rtdc_sensor_t'(cfg[rtdc_pkg::RTDC_TYPE_MSB:rtdc_pkg::RTDC_TYPE_LSB]); // R1
    assign report_resistance = cfg[rtdc_pkg::RTDC_QTY_BIT]; // R2
    assign three_wire        = cfg[rtdc_pkg::RTDC_WIRE_BIT]; // R3
    assign reject_60hz       = cfg[rtdc_pkg::RTDC_REJ_BIT]; // R4
    assign filter_sel        = cfg[rtdc_pkg::RTDC_FILT_MSB:rtdc_pkg::RTDC_FILT_LSB]; // R5

    // ---------------------------------------------------------------
    // register port answer
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && !reg_wr && hit_cfg(reg_addr)) begin
            reg_rdata <= {rtdc_pkg::RTDC_UPPER_ZERO, cfg}; // R10
        end else if (reg_rd && !reg_wr && hit_meas(reg_addr)) begin
            reg_rdata <= third_analog_channel;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_ack <= req && (wr_cfg || (!reg_wr && (hit_cfg(reg_addr) || hit_meas(reg_addr))));
            reg_err <= req && !(wr_cfg || (!reg_wr && (hit_cfg(reg_addr) || hit_meas(reg_addr))));
        end
    end

    // ---------------------------------------------------------------
    // measurement scaling
    // ---------------------------------------------------------------
    rtdc_scale #(
        .RES_W             (RES_W)
    ) u_scale (
        .clock             (clock),
        .rst_n             (rst_n),
        .conv_valid        (conv_valid),
        .conv_temp         (conv_temp),
        .conv_res          (conv_res),
        .sensor_type       (sensor_type),
        .report_resistance (report_resistance),
        .meas              (third_analog_channel),
        .meas_update       (meas_update)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_type_reset;
        @(posedge clock) $past(!rst_n) && rst_n && !$past(wr_cfg) |-> sensor_type == rtdc_pkg::RTDC_PLAT_100;
    endproperty
    a_type_reset: assert property (p_type_reset) else $error("sensor type not cleared by reset"); // R1

    property p_type_write;
        @(posedge clock) disable iff (!rst_n)
            wr_cfg |=> sensor_type == rtdc_pkg::rtdc_sensor_t'($past(reg_wdata[7:6]));
    endproperty
    a_type_write: assert property (p_type_write) else $error("sensor type not taken from write"); // R1

    property p_qty_reset;
        @(posedge clock) $past(!rst_n) && rst_n && !$past(wr_cfg) |-> !report_resistance;
    endproperty
    a_qty_reset: assert property (p_qty_reset) else $error("quantity select not cleared by reset"); // R2

    property p_wire_rej_write;
        @(posedge clock) disable iff (!rst_n)
            wr_cfg |=> three_wire == $past(reg_wdata[4]) && reject_60hz == $past(reg_wdata[3]);
    endproperty
    a_wire_rej_write: assert property (p_wire_rej_write) else $error("wiring or rejection bit wrong"); // R3 R4

    property p_wire_rej_reset;
        @(posedge clock) $past(!rst_n) && rst_n && !$past(wr_cfg) |-> !three_wire && !reject_60hz;
    endproperty
    a_wire_rej_reset: assert property (p_wire_rej_reset) else $error("wiring or rejection not reset"); // R3 R4

    property p_filt_reset;
        @(posedge clock) $past(!rst_n) && rst_n && !$past(wr_cfg) |-> filter_sel == 3'h2;
    endproperty
    a_filt_reset: assert property (p_filt_reset) else $error("filter select reset value wrong"); // R5

    property p_upper_ignored;
        @(posedge clock) disable iff (!rst_n)
            wr_cfg ##1 (reg_rd && !reg_wr && hit_cfg(reg_addr))
            |=> reg_ack && reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)};
    endproperty
    a_upper_ignored: assert property (p_upper_ignored) else $error("upper bits not read as zero"); // R6 R10

    property p_temp;
        @(posedge clock) disable iff (!rst_n)
            conv_valid && !report_resistance |=> meas_update && third_analog_channel == $past(conv_temp);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not reported"); // R7

    property p_centi_ohm;
        @(posedge clock) disable iff (!rst_n)
            conv_valid && report_resistance && !sensor_type[1] && conv_res <= RES_W'(20'h0_ffff)
            |=> third_analog_channel == 16'($past(conv_res));
    endproperty
    a_centi_ohm: assert property (p_centi_ohm) else $error("hundredths of ohm wrong"); // R8

    property p_deci_ohm;
        @(posedge clock) disable iff (!rst_n)
            conv_valid && report_resistance && sensor_type[1] && conv_res <= RES_W'(20'h9_fff6)
            |=> third_analog_channel == 16'($past(conv_res) / RES_W'(20'h0_000a));
    endproperty
    a_deci_ohm: assert property (p_deci_ohm) else $error("tenths of ohm wrong"); // R9

    property p_hold;
        @(posedge clock) disable iff (!rst_n)
            !conv_valid |=> $stable(third_analog_channel) && !meas_update;
    endproperty
    a_hold: assert property (p_hold) else $error("measurement changed without a conversion"); // R10

    property p_err_unmapped;
        @(posedge clock) disable iff (!rst_n)
            req && !hit_cfg(reg_addr) && (reg_wr || !hit_meas(reg_addr)) |=> reg_err && !reg_ack;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped or read-only access not refused");

endmodule // rtdc_channel

/* verif/rtdc_master.sv */
`timescale 1ns/100ps

module rtdc_master (
    input  wire logic        clock,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err,
    output logic      [15:0] reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata
);
    // ---------------------------------------------------------------
    // idle bus
    // ---------------------------------------------------------------
    initial begin
        reg_addr  = 16'h0000;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_wdata = 16'h0000;
    end

    // ---------------------------------------------------------------
    // one register transfer, answer taken the cycle after
    // ---------------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] resp);
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(posedge clock);
        #1;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        q         = reg_rdata;
        resp      = {reg_ack, reg_err};
    endtask

    // ---------------------------------------------------------------
    // write, then read back in the very next cycle
    // ---------------------------------------------------------------
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
                         output logic [1:0] resp_w, output logic [1:0] resp_r);
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'h1;
        reg_rd    = 1'h0;
        @(posedge clock);
        #1;
        resp_w    = {reg_ack, reg_err};
        reg_wr    = 1'h0;
        reg_rd    = 1'h1;
        @(posedge clock);
        #1;
        reg_rd    = 1'h0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        q         = reg_rdata;
        resp_r    = {reg_ack, reg_err};
    endtask
endmodule // rtdc_master

/* verif/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end

module tb_top;
    logic                   clock        = 1'h0;
    logic                   rst_n        = 1'h0;
    logic                   conv_valid   = 1'h0;
    logic [15:0]            conv_temp    = 16'h0000;
    logic [19:0]            conv_res     = 20'h0_0000;
    logic [15:0]            reg_addr, reg_wdata, reg_rdata, meas, q, wv, exp_meas;
    logic                   reg_wr, reg_rd, reg_ack, reg_err, meas_update;
    logic                   report_resistance, three_wire, reject_60hz;
    logic [2:0]             filter_sel;
    logic [1:0]             resp, rresp;
    logic [7:0]             cfg;
    rtdc_pkg::rtdc_sensor_t sensor_type;
    int                     err_count    = 0;
    int                     total_checks = 0;
    int                     seed         = 29782;

    always #2 clock = ~clock;

    rtdc_channel i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .conv_valid(conv_valid), .conv_temp(conv_temp), .conv_res(conv_res),
        .sensor_type(sensor_type), .report_resistance(report_resistance), .three_wire(three_wire),
        .reject_60hz(reject_60hz), .filter_sel(filter_sel), .third_analog_channel(meas),
        .meas_update(meas_update));

    rtdc_master i_master (.clock(clock), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    // ---------------------------------------------------------------
    // reference model of the measurement word
    // ---------------------------------------------------------------
    function automatic logic [15:0] model(logic [7:0] c, logic [15:0] t, logic [19:0] r);
        int v;
        v = (c[7:6] < 2) ? int'(r) : int'(r) / 10;
        if (!c[5]) return t;
        return (v > 65535) ? 16'hffff : v[15:0];
    endfunction

    task automatic check_cfg(logic [7:0] c);
        i_master.xfer(1'h0, rtdc_pkg::RTDC_CFG_ADDR, 16'h0000, q, resp);
        `CHK("cfg_resp", 2'h2, resp)
        `CHK("cfg_read", {8'h00, c}, q)
        `CHK("sensor_type", c[7:6], sensor_type)
        `CHK("report_res", c[5], report_resistance)
        `CHK("three_wire", c[4], three_wire)
        `CHK("reject_60hz", c[3], reject_60hz)
        `CHK("filter_sel", c[2:0], filter_sel)
    endtask

    task automatic check_meas();
        i_master.xfer(1'h0, rtdc_pkg::RTDC_MEAS_ADDR, 16'h0000, q, resp);
        `CHK("meas_resp", 2'h2, resp)
        `CHK("meas_read", exp_meas, q)
    endtask

    task automatic convert(logic [7:0] c);
        @(posedge clock);
        #1;
        conv_valid = 1'h1;
        conv_temp  = 16'($random(seed));
        conv_res   = 20'($random(seed));
        if (conv_temp[0]) begin
            conv_res[19:16] = 4'h0;
        end
        exp_meas   = model(c, conv_temp, conv_res);
        @(posedge clock);
        #1;
        conv_valid = 1'h0;
        conv_temp  = ~conv_temp;
        conv_res   = ~conv_res;
        `CHK("meas_update", 1'h1, meas_update)
        `CHK("measurement", exp_meas, meas)
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        #1;
        rst_n    = 1'h1;
        cfg      = 8'h02;
        exp_meas = 16'h0000;
        check_cfg(cfg);
        check_meas();
        for (int i = 0; i < 24; i++) begin
            wv      = 16'($random(seed));
            wv[7:5] = i[2:0];
            i_master.xfer(1'h1, rtdc_pkg::RTDC_CFG_ADDR, wv, q, resp);
            `CHK("wr_resp", 2'h2, resp)
            cfg = wv[7:0];
            check_cfg(cfg);
            check_meas();
            convert(cfg);
            check_meas();
        end
        wv = 16'($random(seed));
        i_master.wr_rd(rtdc_pkg::RTDC_CFG_ADDR, wv, q, resp, rresp);
        `CHK("b2b_wr_resp", 2'h2, resp)
        `CHK("b2b_rd_resp", 2'h2, rresp)
        `CHK("b2b_read", {8'h00, wv[7:0]}, q)
        cfg = wv[7:0];
        check_cfg(cfg);
        i_master.xfer(1'h1, rtdc_pkg::RTDC_MEAS_ADDR, 16'hffff, q, resp);
        `CHK("ro_write", 2'h1, resp)
        check_meas();
        i_master.xfer(1'h1, 16'h9c46, 16'h00ff, q, resp);
        `CHK("unmapped_wr", 2'h1, resp)
        i_master.xfer(1'h0, 16'h0000, 16'h0000, q, resp);
        `CHK("unmapped_rd", 2'h1, resp)
        check_cfg(cfg);
        @(posedge clock);
        #1;
        rst_n = 1'h0;
        repeat (2) @(posedge clock);
        #1;
        rst_n    = 1'h1;
        cfg      = 8'h02;
        exp_meas = 16'h0000;
        check_cfg(cfg);
        check_meas();
        conclude;
    end

    initial begin
        #40000;
        err_count++;
        conclude;
    end
endmodule // tb_top
